// [core/sms_top.sv]
// Spindle motor servo: APB register file, mode sequencer, loop filter and output formats.
// Assumes decoder inputs are synchronous to clk_sys and an external bridge drives the motor.
`timescale 1ns/10ps
`default_nettype none
`include "sms_defs.svh"
module sms_top (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [6:0]  fifoFill,
  input  wire logic [7:0]  pllFreq,
  input  wire logic [11:0] discSpeed,
  input  wire logic        fifoOverflow,
  input  wire logic        cdRomData,
  output logic             motorDriveOutA,
  output logic             motorDriveOutB,
  output logic             motorAuxOutC,
  output logic             motorAuxOutD,
  output logic             pllReset,
  output logic             fifoReset,
  output logic             audioMute,
  output logic             dataMute,
  output logic             concealStrobe,
  output logic             motorStoppedFlag
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rstMeta;
  logic rstN;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // ****************************************
  // Register decode
  // ****************************************
  function automatic logic [2:0] regIndex(input logic [11:0] addr);
    if (addr == `SMS_ADDR_MODE) begin
      regIndex = 3'h0;
    end else if (addr == `SMS_ADDR_CFG) begin
      regIndex = 3'h1;
    end else if (addr == `SMS_ADDR_LOOP) begin
      regIndex = 3'h2;
    end else if (addr == `SMS_ADDR_STATUS) begin
      regIndex = 3'h3;
    end else begin
      regIndex = 3'h7;
    end
  endfunction

  sms_pkg::sms_mode_e modeReq;
  sms_pkg::sms_mode_e actMode;
  sms_pkg::sms_mode_e next_actMode;
  sms_pkg::sms_fmt_e  fmtReq;
  sms_pkg::sms_fmt_e  actFmt;
  logic        antiWindup;
  logic [1:0]  powerLim;
  logic [1:0]  ospSel;
  logic        brakeSel;
  logic [2:0]  gainSel;
  logic [1:0]  f4Sel;
  logic [1:0]  f3Sel;
  logic        saturated;
  logic        updTick;
  logic        autoSwitch;
  logic [31:0] readValue;
  logic [2:0]  idx;
  logic        apbDone;
  logic        apbWrite;

  assign idx      = regIndex(paddr);
  assign apbDone  = psel & penable & pready;
  assign apbWrite = apbDone & pwrite;

  always_comb begin
    readValue = 32'h0000_0000;
    case (idx)
      3'h0: readValue = {28'h000_0000, antiWindup, modeReq};
      3'h1: readValue = {25'h000_0000, brakeSel, ospSel, powerLim, fmtReq};
      3'h2: readValue = {24'h00_0000, f3Sel, f4Sel, 1'b0, gainSel};
      3'h3: readValue = {26'h000_0000, saturated, 1'b0, motorStoppedFlag, actMode};
      default: readValue = 32'h0000_0000;
    endcase
  end

  // One wait state: the answer is registered in the first access cycle
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : readValue;
        pslverr <= (idx == 3'h7);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Automatic switches rewrite the requested mode so the next update does not undo them
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      modeReq    <= sms_pkg::SMS_OFF;
      antiWindup <= 1'b0;
    end else if (autoSwitch) begin
      modeReq <= next_actMode;
    end else if (apbWrite && idx == 3'h0) begin
      modeReq    <= sms_pkg::sms_mode_e'(pwdata[`SMS_MODE_SEL]);
      antiWindup <= pwdata[`SMS_MODE_AWU];
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      fmtReq   <= sms_pkg::SMS_FMT_PDM;
      powerLim <= 2'b00;
      ospSel   <= 2'b00;
      brakeSel <= 1'b0;
    end else if (apbWrite && idx == 3'h1) begin
      fmtReq   <= sms_pkg::sms_fmt_e'(pwdata[`SMS_CFG_FMT]);
      powerLim <= pwdata[`SMS_CFG_PLIM];
      ospSel   <= pwdata[`SMS_CFG_OSP];
      brakeSel <= pwdata[`SMS_CFG_BRAKE];
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      gainSel <= 3'b000;
      f4Sel   <= 2'b00;
      f3Sel   <= 2'b00;
    end else if (apbWrite && idx == 3'h2) begin
      gainSel <= pwdata[`SMS_LOOP_GAIN];
      f4Sel   <= pwdata[`SMS_LOOP_F4];
      f3Sel   <= pwdata[`SMS_LOOP_F3];
    end
  end

  // ****************************************
  // Rate ticks, all scaled by overspeed
  // ****************************************
  logic [31:0] tickInc [4];
  logic [31:0] phase [4];
  logic [3:0]  tick;

  always_comb begin
    tickInc[0] = `SMS_INC(`SMS_PDM_HZ) << ospSel;
    tickInc[1] = `SMS_INC(`SMS_PWM_HZ * `SMS_PWM_STEPS) << ospSel;
    tickInc[2] = `SMS_INC(`SMS_FPOS_HZ * `SMS_FPOS_STEPS) << ospSel;
    tickInc[3] = `SMS_INC(`SMS_PLL_PDM_HZ) << ospSel;
  end

  generate
    for (genvar g = 0; g < 4; g++) begin : gTick
      always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
          phase[g] <= 32'h0000_0000;
          tick[g]  <= 1'b0;
        end else begin
          {tick[g], phase[g]} <= {1'b0, phase[g]} + {1'b0, tickInc[g]};
        end
      end
    end
  endgenerate

  // Servo updates once per PWM period
  logic [7:0] updCnt;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      updCnt  <= 8'h00;
      updTick <= 1'b0;
    end else begin
      updTick <= tick[1] && updCnt == 8'hFF;
      if (tick[1]) begin
        updCnt <= updCnt + 8'h01;
      end
    end
  end

  // ****************************************
  // Mode sequencer
  // ****************************************
  logic speedHigh;
  logic speedLow;

  assign speedHigh  = discSpeed >= `SMS_SPEED_75;
  assign speedLow   = discSpeed <= (brakeSel ? `SMS_SPEED_6 : `SMS_SPEED_12);
  assign autoSwitch = updTick && next_actMode != modeReq;

  always_comb begin
    next_actMode = modeReq;
    case (actMode)
      sms_pkg::SMS_START2: begin
        if (modeReq == sms_pkg::SMS_START2 && speedHigh) begin
          next_actMode = sms_pkg::SMS_JUMP;
        end
      end
      sms_pkg::SMS_STOP2: begin
        if (modeReq == sms_pkg::SMS_STOP2 && speedLow) begin
          next_actMode = sms_pkg::SMS_OFF;
        end
      end
      default: next_actMode = modeReq;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      actMode <= sms_pkg::SMS_OFF;
      actFmt  <= sms_pkg::SMS_FMT_PDM;
    end else if (updTick) begin
      actMode <= next_actMode;
      actFmt  <= fmtReq;
    end
  end

  // Stopped flag: a new stop event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      motorStoppedFlag <= 1'b0;
    end else if (autoSwitch && next_actMode == sms_pkg::SMS_OFF) begin
      motorStoppedFlag <= 1'b1;
    end else if (apbWrite && idx == 3'h3 && pwdata[`SMS_STAT_STOP]) begin
      motorStoppedFlag <= 1'b0;
    end
  end

  logic playEntry;

  assign playEntry = updTick && next_actMode == sms_pkg::SMS_PLAY && actMode != sms_pkg::SMS_PLAY;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pllReset      <= 1'b0;
      fifoReset     <= 1'b0;
      audioMute     <= 1'b1;
      dataMute      <= 1'b1;
      concealStrobe <= 1'b0;
    end else begin
      pllReset      <= actMode == sms_pkg::SMS_START1;
      // Held in jump, one pulse on play entry, one pulse on overflow in play
      fifoReset     <= actMode == sms_pkg::SMS_JUMP || actMode == sms_pkg::SMS_JUMP1
                       || playEntry
                       || (actMode == sms_pkg::SMS_PLAY && fifoOverflow);
      audioMute     <= actMode != sms_pkg::SMS_PLAY;
      dataMute      <= actMode != sms_pkg::SMS_PLAY && !cdRomData;
      concealStrobe <= actMode == sms_pkg::SMS_PLAY && fifoOverflow;
    end
  end

  // ****************************************
  // Loop filter
  // ****************************************
  // Gains in eighths, crossovers in tenths of Hz per unit overspeed
  function automatic logic [7:0] gainCoef(input logic [2:0] sel);
    case (sel)
      3'd0: gainCoef = 8'd16;
      3'd1: gainCoef = 8'd20;
      3'd2: gainCoef = 8'd32;
      3'd3: gainCoef = 8'd40;
      3'd4: gainCoef = 8'd64;
      3'd5: gainCoef = 8'd80;
      3'd6: gainCoef = 8'd128;
      default: gainCoef = 8'd160;
    endcase
  endfunction

  logic signed [7:0]  err;
  logic signed [7:0]  errPrev;
  logic signed [23:0] integ;
  logic signed [9:0]  demand;
  logic signed [17:0] propTerm;
  logic signed [17:0] leadTerm;
  logic signed [23:0] integStep;
  logic signed [19:0] sum;
  logic signed [9:0]  next_servo;
  logic signed [9:0]  limitDrive;
  logic        [5:0]  f4Coef;
  logic        [5:0]  f3Coef;
  logic        [8:0]  limFrac;

  assign err = $signed({1'b0, fifoFill}) - $signed(`SMS_FIFO_HALF);

  always_comb begin
    case (f4Sel)
      2'd0: f4Coef = 6'd5;
      2'd1: f4Coef = 6'd7;
      2'd2: f4Coef = 6'd14;
      default: f4Coef = 6'd28;
    endcase
    case (f3Sel)
      2'd0: f3Coef = 6'd9;
      2'd1: f3Coef = 6'd17;
      default: f3Coef = 6'd34;
    endcase
    case (powerLim)
      2'd0: limFrac = 9'd256;
      2'd1: limFrac = 9'd192;
      2'd2: limFrac = 9'd128;
      default: limFrac = 9'd95;
    endcase
  end

  always_comb begin
    propTerm   = 18'(err * $signed({1'b0, gainCoef(gainSel)}));
    leadTerm   = 18'((err - errPrev) * $signed({1'b0, f3Coef})) <<< ospSel;
    integStep  = 24'(err * $signed({1'b0, f4Coef})) <<< ospSel;
    sum        = 20'(propTerm >>> 3) + 20'(leadTerm >>> 3) + 20'(integ >>> 8);
    saturated  = sum > $signed({10'h000, `SMS_DRIVE_MAX}) || sum < -$signed({10'h000, `SMS_DRIVE_MAX});
    if (sum > $signed({10'h000, `SMS_DRIVE_MAX})) begin
      next_servo = $signed(`SMS_DRIVE_MAX);
    end else if (sum < -$signed({10'h000, `SMS_DRIVE_MAX})) begin
      next_servo = -$signed(`SMS_DRIVE_MAX);
    end else begin
      next_servo = sum[9:0];
    end
    limitDrive = $signed(10'((19'(`SMS_DRIVE_MAX) * 19'(limFrac)) >> 8));
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      integ   <= 24'sd0;
      errPrev <= 8'sd0;
      demand  <= 10'sd0;
    end else if (updTick) begin
      errPrev <= err;
      // Drive follows the mode entered at this update, not the one being left
      case (next_actMode)
        sms_pkg::SMS_PLAY: begin
          if (!(antiWindup && saturated)) begin
            integ <= integ + integStep;
          end
          demand <= next_servo;
        end
        sms_pkg::SMS_JUMP: demand <= next_servo;
        sms_pkg::SMS_JUMP1: begin
          integ  <= 24'sd0;
          demand <= next_servo;
        end
        sms_pkg::SMS_START1, sms_pkg::SMS_START2: demand <= limitDrive;
        sms_pkg::SMS_STOP1, sms_pkg::SMS_STOP2: demand <= -limitDrive;
        default: demand <= 10'sd0;
      endcase
    end
  end

  // ****************************************
  // Modulators and output formats
  // ****************************************
  logic [9:0] pdmLevel;
  logic [9:0] accLevel;
  logic [9:0] brkLevel;
  logic       pdmOut;
  logic       accOut;
  logic       brkOut;
  logic       fposOut;
  logic       pllOut;

  // Mid-scale density is the idle point, so zero demand steers nothing
  assign pdmLevel = 10'(demand) + 10'h200;
  assign accLevel = demand > 10'sd0 ? 10'(demand) >> 1 : 10'h000;
  assign brkLevel = demand < 10'sd0 ? 10'(-demand) >> 1 : 10'h000;

  sms_modulator uPdm (
    .clk     (clk_sys),
    .rstN    (rstN),
    .tick    (tick[0]),
    .pwmMode (1'b0),
    .period  (10'h000),
    .level   (pdmLevel),
    .out     (pdmOut)
  );

  sms_modulator uAcc (
    .clk     (clk_sys),
    .rstN    (rstN),
    .tick    (tick[1]),
    .pwmMode (1'b1),
    .period  (10'(`SMS_PWM_STEPS)),
    .level   (accLevel),
    .out     (accOut)
  );

  sms_modulator uBrk (
    .clk     (clk_sys),
    .rstN    (rstN),
    .tick    (tick[1]),
    .pwmMode (1'b1),
    .period  (10'(`SMS_PWM_STEPS)),
    .level   (brkLevel),
    .out     (brkOut)
  );

  // Offset of four frames in a twenty-frame span puts half full at 60 percent
  sms_modulator uFpos (
    .clk     (clk_sys),
    .rstN    (rstN),
    .tick    (tick[2]),
    .pwmMode (1'b1),
    .period  (10'(`SMS_FPOS_STEPS)),
    .level   ({3'b000, fifoFill} + `SMS_FPOS_OFFS),
    .out     (fposOut)
  );

  sms_modulator uPll (
    .clk     (clk_sys),
    .rstN    (rstN),
    .tick    (tick[3]),
    .pwmMode (1'b0),
    .period  (10'h000),
    .level   ({pllFreq, 2'b00}),
    .out     (pllOut)
  );

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      motorDriveOutA <= 1'b0;
      motorDriveOutB <= 1'b1;
      motorAuxOutC   <= 1'b0;
      motorAuxOutD   <= 1'b0;
    end else begin
      case (actFmt)
        sms_pkg::SMS_FMT_PDM: begin
          motorDriveOutA <= pdmOut;
          motorDriveOutB <= ~pdmOut;
          motorAuxOutC   <= 1'b0;
          motorAuxOutD   <= 1'b0;
        end
        sms_pkg::SMS_FMT_PWM2: begin
          motorDriveOutA <= accOut;
          motorDriveOutB <= brkOut;
          motorAuxOutC   <= 1'b0;
          motorAuxOutD   <= 1'b0;
        end
        sms_pkg::SMS_FMT_PWM4: begin
          motorDriveOutA <= accOut;
          motorDriveOutB <= brkOut;
          motorAuxOutC   <= demand > 10'sd0;
          motorAuxOutD   <= demand < 10'sd0;
        end
        default: begin
          // Servo result unused here; controller owns speed in lock-to-disc use
          motorDriveOutA <= fposOut;
          motorDriveOutB <= pllOut;
          motorAuxOutC   <= 1'b0;
          motorAuxOutD   <= 1'b0;
        end
      endcase
    end
  end

endmodule // sms_top
`default_nettype wire

// [core/sms_defs.svh]
// Constants of the spindle motor servo: register map, fields, reset values, rates.
// Assumes a 100 MHz system clock; rates are turned into phase increments here.
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define SMS_ADDR_MODE    12'h000
`define SMS_ADDR_CFG     12'h004
`define SMS_ADDR_LOOP    12'h008
`define SMS_ADDR_STATUS  12'h00C

`define SMS_MODE_RESET   32'h0000_0000
`define SMS_CFG_RESET    32'h0000_0000
`define SMS_LOOP_RESET   32'h0000_0000

// ****************************************
// Field positions
// ****************************************
`define SMS_MODE_SEL     2:0
`define SMS_MODE_AWU     3
`define SMS_CFG_FMT      1:0
`define SMS_CFG_PLIM     3:2
`define SMS_CFG_OSP      5:4
`define SMS_CFG_BRAKE    6
`define SMS_LOOP_GAIN    2:0
`define SMS_LOOP_F4      5:4
`define SMS_LOOP_F3      7:6
`define SMS_STAT_STOP    3

// ****************************************
// Rates and derived phase increments
// ****************************************
`define SMS_CLK_HZ       100000000
`define SMS_PDM_HZ       1000000
`define SMS_PWM_HZ       22050
`define SMS_PWM_STEPS    256
`define SMS_FPOS_HZ      300
`define SMS_FPOS_STEPS   160
`define SMS_PLL_PDM_HZ   4230000
`define SMS_INC(hz)      32'(((64'd1 << 32) * (hz)) / `SMS_CLK_HZ)

// ****************************************
// Speed and FIFO thresholds
// ****************************************
`define SMS_SPEED_NOM    12'h800
`define SMS_SPEED_75     12'(((`SMS_SPEED_NOM) * 75) / 100)
`define SMS_SPEED_12     12'(((`SMS_SPEED_NOM) * 12) / 100)
`define SMS_SPEED_6      12'(((`SMS_SPEED_NOM) * 6) / 100)
`define SMS_FIFO_HALF    8'h40
`define SMS_FPOS_OFFS    10'h020
`define SMS_DRIVE_MAX    10'h1FF

`endif

// [core/sms_pkg.sv]
// Types shared by the spindle motor servo files.
// Assumes nothing of its surroundings.
package sms_pkg;

  typedef enum logic [2:0] {
    SMS_OFF    = 3'b000,
    SMS_START1 = 3'b001,
    SMS_START2 = 3'b010,
    SMS_JUMP   = 3'b011,
    SMS_JUMP1  = 3'b100,
    SMS_PLAY   = 3'b101,
    SMS_STOP1  = 3'b110,
    SMS_STOP2  = 3'b111
  } sms_mode_e;

  typedef enum logic [1:0] {
    SMS_FMT_PDM  = 2'b00,
    SMS_FMT_PWM2 = 2'b01,
    SMS_FMT_PWM4 = 2'b10,
    SMS_FMT_FPOS = 2'b11
  } sms_fmt_e;

endpackage

// [core/sms_modulator.sv]
// Pulse width or pulse density modulator stepped by a tick.
// Assumes tick is a one-cycle strobe in the clk domain; level is sampled at period start in PWM mode, on every tick in PDM mode.
`timescale 1ns/10ps
`default_nettype none
module sms_modulator (
  input  wire logic       clk,
  input  wire logic       rstN,
  input  wire logic       tick,
  input  wire logic       pwmMode,
  input  wire logic [9:0] period,
  input  wire logic [9:0] level,
  output logic            out
);
  logic [9:0] cnt;
  logic [9:0] acc;
  logic [9:0] held;
  logic [10:0] next_acc;

  assign next_acc = {1'b0, acc} + {1'b0, held};

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt  <= 10'h000;
      acc  <= 10'h000;
      held <= 10'h000;
      out  <= 1'b0;
    end else if (tick) begin
      // In PWM mode the level only changes at a period boundary, so a new demand never cuts a pulse short; PDM takes it every tick
      if (cnt == period - 10'h001 || !pwmMode) begin
        cnt  <= 10'h000;
        held <= level;
      end else begin
        cnt <= cnt + 10'h001;
      end
      if (pwmMode) begin
        out <= (cnt < held);
      end else begin
        acc <= next_acc[9:0];
        out <= next_acc[10];
      end
    end
  end
endmodule // sms_modulator
`default_nettype wire

// [tb/sms_bridge.sv]
// Motor bridge model: turns the two drive lines into disc speed and PLL level.
// Assumes the drive lines are registered servo outputs on clk.
`timescale 1ns/10ps
`default_nettype none
module sms_bridge (
  input  wire logic        clk,
  input  wire logic        driveA,
  input  wire logic        driveB,
  output logic      [11:0] discSpeed,
  output logic      [7:0]  pllFreq
);
  // ****************
  // Disc inertia
  // ****************
  // One step per cycle of net drive; crude, but monotone and clamped
  // No lock-to-disc operation is modelled, so the testbench uses only the PDM, PWM2 and PWM4 formats
  initial discSpeed = 12'h000;
  always @(posedge clk) begin
    if (driveA && !driveB && discSpeed != 12'hFFF)
      discSpeed <= discSpeed + 12'h001;
    else if (!driveA && driveB && discSpeed != 12'h000)
      discSpeed <= discSpeed - 12'h001;
  end
  assign pllFreq = discSpeed[11:4];
endmodule // sms_bridge
`default_nettype wire

// [tb/sms_sva.sv]
// Checker of the servo's APB answers and mode side effects.
// Assumes it is bound to sms_top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module sms_sva (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fifoOverflow,
  input wire logic        concealStrobe,
  input wire logic        pllReset,
  input wire logic        audioMute,
  input wire logic        fifoReset,
  input wire logic        motorStoppedFlag
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  property p_wait; s_access |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not one cycle after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_errdata; pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_errdata: assert property (p_errdata) else $error("unmapped read not zero");
  property p_conceal; concealStrobe |-> $past(fifoOverflow); endproperty
  a_conceal: assert property (p_conceal) else $error("conceal without overflow");
  property p_start1; pllReset |-> audioMute; endproperty
  a_start1: assert property (p_start1) else $error("audio open in start mode");
  property p_stop; $rose(motorStoppedFlag) |-> audioMute; endproperty
  a_stop: assert property (p_stop) else $error("stop flag outside muted mode");
  property p_play; $fell(audioMute) |-> fifoReset || $past(fifoReset); endproperty
  a_play: assert property (p_play) else $error("unmute without fifo reset");
endmodule // sms_sva
`default_nettype wire

// [tb/sms_top_tb.sv]
// Testbench of the spindle motor servo: APB tasks, bridge model, mode walk.
// Assumes the checker and the bridge model are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module sms_top_tb;
  logic        clk_sys = 1'b0, arst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, discSpeed;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdData;
  logic [7:0]  pllFreq;
  logic        pready, pslverr, rdErr, fifoOverflow = 1'b0, cdRomData = 1'b0;
  logic        outA, outB, outC, outD, pllReset, fifoReset, audioMute, dataMute, concealStrobe, stopped;
  int          failures = 0, totalChecks = 0, cyc = 0, bad, highs, last, hb;
  always #5 clk_sys = ~clk_sys;
  sms_top sms_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifoFill(7'h40), .pllFreq(pllFreq), .discSpeed(discSpeed),
    .fifoOverflow(fifoOverflow), .cdRomData(cdRomData), .motorDriveOutA(outA),
    .motorDriveOutB(outB), .motorAuxOutC(outC), .motorAuxOutD(outD), .pllReset(pllReset),
    .fifoReset(fifoReset), .audioMute(audioMute), .dataMute(dataMute),
    .concealStrobe(concealStrobe), .motorStoppedFlag(stopped));
  sms_bridge sms_bridge_inst (.clk(clk_sys), .driveA(outA), .driveB(outB),
    .discSpeed(discSpeed), .pllFreq(pllFreq));
  // ****************
  // Tasks
  // ****************
  task automatic report_and_stop;
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pollMode(input logic [2:0] m);
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, 12'h00C, 32'h0000_0000);
      if (rdData[2:0] === m) break;
    end
    chk(32'(rdData[2:0]), 32'(m));
  endtask
  // Counts high cycles over n cycles once a PWM period has latched the new level; C weighs twice
  task automatic watch(input int n);
    highs = 0;
    hb = 0;
    bad = 0;
    repeat (4700) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      highs += int'(outA);
      hb += int'(outB);
      bad += 2 * int'(outC) + int'(outD);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      report_and_stop();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(32'(outA ^ outB), 32'h0000_0001);
    chk(32'(audioMute), 32'h0000_0001);
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0000_0000);
      chk(rdData, 32'h0000_0000);
    end
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0000_0000, rdErr}, 32'h0000_0001);
    // Off mode in pulse density: complement lines, toggles on 1 MHz ticks only
    bad = 0;
    highs = 0;
    last = 0;
    for (int i = 1; i <= 1000; i++) begin
      @(posedge clk_sys);
      if (outB !== ~outA) bad++;
      if (outC | outD) bad++;
      highs += int'(outA);
      if (outA !== outB && i > 1 && last > 0 && (i - last) % 100 != 0 && outA != hb[0]) bad++;
      if (outA != hb[0]) last = i;
      hb = int'(outA);
    end
    chk(32'(bad), 32'h0000_0000);
    chk(32'(highs >= 400 && highs <= 600), 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0001);
    for (int i = 0; i < 6000 && pllReset !== 1'b1; i++) @(posedge clk_sys);
    chk(32'(pllReset), 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0002);
    pollMode(3'h3);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(32'(rdData[2:0]), 32'h0000_0003);
    cdRomData <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(32'({audioMute, dataMute}), 32'h0000_0002);
    cdRomData <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_0005);
    for (int i = 0; i < 6000 && audioMute !== 1'b0; i++) @(posedge clk_sys);
    chk(32'(audioMute), 32'h0000_0000);
    @(posedge clk_sys);
    fifoOverflow <= 1'b1;
    @(posedge clk_sys);
    fifoOverflow <= 1'b0;
    bad = 0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      bad += int'(fifoReset & concealStrobe);
    end
    chk(32'(bad > 0), 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0007);
    for (int i = 0; i < 20000 && stopped !== 1'b1; i++) @(posedge clk_sys);
    chk(32'(stopped), 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(32'(rdData[3:0]), 32'h0000_0008);
    apb(1'b1, 12'h00C, 32'h0000_0008);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk(32'(rdData[3]), 32'h0000_0000);
    // Two-line PWM while braking: acceleration line stays low
    apb(1'b1, 12'h004, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0006);
    pollMode(3'h6);
    watch(5000);
    chk(32'({highs == 0, hb > 0}), 32'h0000_0003);
    // Four-line PWM while braking: brake line pulses, braking direction line D stays high, A and C stay low
    apb(1'b1, 12'h004, 32'h0000_0002);
    watch(5000);
    chk(32'({highs == 0, hb > 0, bad == 5000}), 32'h0000_0007);
    apb(1'b1, 12'h000, 32'h0000_0000);
    pollMode(3'h0);
    watch(5000);
    chk(32'(highs + hb + bad), 32'h0000_0000);
    report_and_stop();
  end
endmodule // sms_top_tb
bind sms_top sms_sva sms_sva_inst (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fifoOverflow(fifoOverflow),
  .concealStrobe(concealStrobe), .pllReset(pllReset), .audioMute(audioMute), .fifoReset(fifoReset),
  .motorStoppedFlag(motorStoppedFlag));
`default_nettype wire
